// ---- hdl/rci_top.sv ----
// Remote command interface: queues, line parser, reply routing, trigger and sync
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps

module rci_top import rci_pkg::*; #(
	parameter int DEPTH    = 256,
	parameter int SOFTWARE_TRIGGER_COMMAND_GAP = RCI_SOFTWARE_TRIGGER_COMMAND_GAP_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Serial characters
	input  wire logic        ser_rx_valid,
	input  wire logic [7:0]  ser_rx_data,
	output logic             ser_tx_valid,
	output logic      [7:0]  ser_tx_data,
	input  wire logic        ser_tx_ready,
	output logic             ser_cts,
	input  wire logic        ser_dtr,
	output logic      [3:0]  ser_word_len,
	output logic      [1:0]  ser_parity,
	output logic      [2:0]  ser_baud,
	// Instrument bus characters
	input  wire logic        bus_rx_valid,
	input  wire logic [7:0]  bus_rx_data,
	input  wire logic        bus_rx_eoi,
	output logic             bus_rx_ready,
	output logic             bus_tx_valid,
	output logic      [7:0]  bus_tx_data,
	input  wire logic        bus_tx_ready,
	output logic      [4:0]  bus_address,
	input  wire logic        bus_get,
	input  wire logic        bus_spoll_done,
	// Command engine
	output logic             cmd_valid,
	output logic      [7:0]  cmd_char,
	output logic             cmd_last,
	input  wire logic        exec_done,
	input  wire logic        exec_err,
	input  wire logic        resp_valid,
	input  wire logic [7:0]  resp_char,
	input  wire logic        resp_eol,
	input  wire logic        srq_req,
	input  wire logic        sw_software_trigger_command,
	// Trigger, storage and sync
	input  wire logic        ext_software_trigger_command,
	output logic             sample_strobe,
	output logic             storing,
	input  wire logic        osc_sine_pos,
	output logic             sync_out,
	// Indicators
	output logic             led_activity,
	output logic             led_error,
	output logic             led_srq
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int GW = $clog2(SOFTWARE_TRIGGER_COMMAND_GAP + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		rci_ex_t       ex;
		logic [AW-1:0] in_wp;
		logic [AW-1:0] in_rp;
		logic [CW-1:0] in_cnt;
		logic [CW-1:0] lines;
		logic [AW-1:0] out_wp;
		logic [AW-1:0] out_rp;
		logic [CW-1:0] out_cnt;
		logic          tx_v;
		logic [7:0]    tx_d;
		logic          cmd_v;
		logic [7:0]    cmd_c;
		logic          cmd_l;
		logic [7:0]    ctrl;
		logic [4:0]    gaddr;
		logic [7:0]    hidx;
		logic [7:0]    hist_wp;
		logic          ready;
		logic          err;
		logic          srq;
		logic          store;
		logic          software_trigger_command_prev;
		logic [GW-1:0] gap;
		logic          sample;
		logic          act;
		logic          errp;
		logic          sync;
		logic [31:0]   rdata;
	} rci_state_t;

	rci_state_t s_q;
	rci_state_t s_d;

	logic [8:0] in_mem [DEPTH];
	logic [7:0] out_mem [DEPTH];
	logic [7:0] hist_mem [256];

	logic       in_push;
	logic [8:0] in_ent;
	logic       hist_push;
	logic [7:0] rx_ch;
	logic       out_push;
	logic [7:0] out_ch;
	logic       flush;
	logic       tx_take;
	logic       software_trigger_command_ev;
	logic [7:0] up_ch;
	logic       rx_term;
	logic       rx_any;

	always_comb begin
		s_d       = s_q;
		in_push   = 1'b0;
		in_ent    = 9'h000;
		hist_push = 1'b0;
		out_push  = 1'b0;
		out_ch    = 8'h00;
		flush     = 1'b0;
		s_d.act   = 1'b0;
		s_d.errp  = 1'b0;
		s_d.sample = 1'b0;
		s_d.cmd_v = 1'b0;
		s_d.cmd_l = 1'b0;

		// Receive: serial first, bus held off the same cycle
		rx_any  = ser_rx_valid | (bus_rx_valid & bus_rx_ready);
		rx_ch   = ser_rx_valid ? ser_rx_data : bus_rx_data;
		rx_term = ser_rx_valid ? (rx_ch == RCI_CH_LF || rx_ch == RCI_CH_CR)
		                       : (rx_ch == RCI_CH_LF || bus_rx_eoi);
		up_ch   = (rx_ch >= RCI_CH_A && rx_ch <= RCI_CH_Z) ? rx_ch - RCI_CASE : rx_ch;
		if (rx_any) begin
			hist_push = 1'b1;
			s_d.hist_wp = s_q.hist_wp + 8'h01;
			s_d.act = 1'b1;
			// Same queue for both sources, so common commands parse alike
			if (rx_ch != RCI_CH_SP || rx_term) begin
				if (s_q.in_cnt == FULL) begin
					flush = 1'b1;
				end else begin
					in_push = 1'b1;
					in_ent = {rx_term, up_ch};
				end
			end
		end

		// Replies: engine char or terminator for the selected port
		if (resp_eol) begin
			out_push = 1'b1;
			out_ch = s_q.ctrl[RCI_CTRL_OSEL] ? RCI_CH_LF : RCI_CH_CR;
		end else if (resp_valid) begin
			out_push = 1'b1;
			out_ch = resp_char;
		end
		if (out_push && s_q.out_cnt == FULL) begin
			out_push = 1'b0;
			flush = 1'b1;
		end

		// Output drain to the one selected interface
		tx_take = s_q.ctrl[RCI_CTRL_OSEL] ? (bus_tx_valid & bus_tx_ready) : (ser_tx_valid & ser_tx_ready);
		if (tx_take) begin
			s_d.tx_v = 1'b0;
			s_d.act = 1'b1;
		end
		if ((!s_q.tx_v || tx_take) && s_q.out_cnt != '0 && (s_q.ctrl[RCI_CTRL_OSEL] || ser_dtr)) begin
			s_d.tx_v = 1'b1;
			s_d.tx_d = out_mem[s_q.out_rp];
			s_d.out_rp = s_q.out_rp + 1'b1;
		end
		if (out_push) begin
			s_d.out_wp = s_q.out_wp + 1'b1;
		end
		s_d.out_cnt = s_q.out_cnt + CW'(out_push) - CW'(s_d.out_rp != s_q.out_rp);

		// Line execution: a line leaves only once its terminator is queued
		if (in_push) begin
			s_d.in_wp = s_q.in_wp + 1'b1;
		end
		case (s_q.ex)
			RCI_EX_IDLE: begin
				if (s_q.lines != '0) begin
					s_d.ready = 1'b0;
					s_d.ex = RCI_EX_SEND;
				end
			end
			RCI_EX_SEND: begin
				s_d.cmd_v = 1'b1;
				s_d.cmd_c = in_mem[s_q.in_rp][7:0];
				s_d.cmd_l = in_mem[s_q.in_rp][8];
				s_d.in_rp = s_q.in_rp + 1'b1;
				if (in_mem[s_q.in_rp][8]) begin
					s_d.ex = RCI_EX_WAIT;
				end
			end
			RCI_EX_WAIT: begin
				// Later lines stay queued until this one completes
				if (exec_done) begin
					s_d.ready = 1'b1;
					s_d.ex = RCI_EX_IDLE;
				end
			end
			default: s_d.ex = RCI_EX_IDLE;
		endcase
		s_d.in_cnt = s_q.in_cnt + CW'(in_push) - CW'(s_d.in_rp != s_q.in_rp);
		s_d.lines = s_q.lines + CW'(in_push & in_ent[8]) - CW'(s_d.ex == RCI_EX_WAIT && s_q.ex == RCI_EX_SEND);

		if (flush) begin
			s_d.in_wp = '0;
			s_d.in_rp = '0;
			s_d.in_cnt = '0;
			s_d.lines = '0;
			s_d.out_wp = '0;
			s_d.out_rp = '0;
			s_d.out_cnt = '0;
			s_d.tx_v = 1'b0;
			if (s_q.ex != RCI_EX_WAIT) begin
				s_d.ex = (s_q.ex == RCI_EX_SEND) ? RCI_EX_WAIT : RCI_EX_IDLE;
				s_d.ready = (s_q.ex != RCI_EX_SEND);
			end
		end
		if (flush || exec_err) begin
			s_d.errp = 1'b1;
		end

		// Register port
		s_d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				RCI_REG_CTRL: s_d.rdata = {24'h00_0000, s_q.ctrl};
				RCI_REG_ADDR: s_d.rdata = {27'h000_0000, s_q.gaddr};
				RCI_REG_STAT: s_d.rdata = {27'h000_0000, s_q.store, s_q.err, s_q.srq, s_q.ready, 1'b0};
				RCI_REG_HIDX: s_d.rdata = {24'h00_0000, s_q.hidx};
				RCI_REG_HDAT: s_d.rdata = {24'h00_0000, hist_mem[8'(s_q.hist_wp + s_q.hidx)]};
				default:      s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				RCI_REG_CTRL: begin
					s_d.ctrl = reg_wdata[7:0];
					s_d.store = 1'b0;
				end
				RCI_REG_ADDR: begin
					if (reg_wdata[4:0] >= RCI_ADDR_MIN && reg_wdata[4:0] <= RCI_ADDR_MAX && reg_wdata[31:5] == '0) begin
						s_d.gaddr = reg_wdata[4:0];
					end else begin
						s_d.errp = 1'b1;
					end
				end
				RCI_REG_STAT: begin
					if (reg_wdata[RCI_STAT_ERR]) begin
						s_d.err = 1'b0;
					end
				end
				RCI_REG_HIDX: s_d.hidx = reg_wdata[7:0];
				default: ;
			endcase
		end
		if (s_d.errp) begin
			s_d.err = 1'b1;
		end

		// Service request: a new request beats a completing poll
		if (bus_spoll_done) begin
			s_d.srq = 1'b0;
		end
		if (srq_req) begin
			s_d.srq = 1'b1;
		end

		// Trigger sources, only acting in a trigger mode
		s_d.software_trigger_command_prev = ext_software_trigger_command;
		software_trigger_command_ev = (ext_software_trigger_command & ~s_q.software_trigger_command_prev) | bus_get | sw_software_trigger_command;
		if (s_q.gap != '0) begin
			s_d.gap = s_q.gap - 1'b1;
		end
		if (software_trigger_command_ev && s_q.gap == '0) begin
			if (s_q.ctrl[RCI_CTRL_TSTART] && !s_q.store) begin
				s_d.store = 1'b1;
				s_d.sample = 1'b1;
			end else if (s_q.ctrl[RCI_CTRL_TRATE]) begin
				s_d.sample = 1'b1;
			end
			if (s_d.sample) begin
				s_d.gap = GW'(SOFTWARE_TRIGGER_COMMAND_GAP - 1);
			end
		end

		s_d.sync = osc_sine_pos;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.ex <= RCI_EX_IDLE;
			s_q.ctrl <= RCI_CTRL_RST;
			s_q.gaddr <= RCI_ADDR_RST;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Queue and history storage
	// ****************************************
	always_ff @(posedge mclk) begin
		if (in_push) begin
			in_mem[s_q.in_wp] <= in_ent;
		end
		if (out_push) begin
			out_mem[s_q.out_wp] <= out_ch;
		end
		if (hist_push) begin
			hist_mem[s_q.hist_wp] <= rx_ch;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata     = s_q.rdata;
	assign ser_tx_valid  = s_q.tx_v & ~s_q.ctrl[RCI_CTRL_OSEL] & ser_dtr;
	assign bus_tx_valid  = s_q.tx_v & s_q.ctrl[RCI_CTRL_OSEL];
	assign ser_tx_data   = s_q.tx_d;
	assign bus_tx_data   = s_q.tx_d;
	assign ser_cts       = (s_q.in_cnt != FULL);
	assign bus_rx_ready  = (s_q.in_cnt != FULL) & ~ser_rx_valid;
	assign ser_word_len  = RCI_WORD_LEN;
	assign ser_parity    = s_q.ctrl[RCI_CTRL_PAR +: 2];
	assign ser_baud      = s_q.ctrl[RCI_CTRL_BAUD +: 3];
	assign bus_address   = s_q.gaddr;
	assign cmd_valid     = s_q.cmd_v;
	assign cmd_char      = s_q.cmd_c;
	assign cmd_last      = s_q.cmd_l;
	assign sample_strobe = s_q.sample;
	assign storing       = s_q.store;
	assign sync_out      = s_q.sync;
	assign led_activity  = s_q.act;
	assign led_error     = s_q.errp;
	assign led_srq       = s_q.srq;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_ready_clear: assert property (s_q.ex == RCI_EX_IDLE && s_q.lines != '0 && !flush |=> !s_q.ready ##1 cmd_valid)
		else $error("ready bit not cleared at line start");
	a_busy_hold: assert property (s_q.ex == RCI_EX_WAIT && !exec_done |=> !s_q.ready && !cmd_valid)
		else $error("second line issued during execution");
	a_no_early: assert property (s_q.ex == RCI_EX_IDLE && s_q.lines == '0 |=> !cmd_valid[*2])
		else $error("command issued without terminator");
	a_dtr_gate: assert property (ser_tx_valid |-> ser_dtr && !s_q.ctrl[RCI_CTRL_OSEL])
		else $error("serial send without DTR or not selected");
	a_bus_route: assert property (bus_tx_valid |-> !ser_tx_valid && s_q.ctrl[RCI_CTRL_OSEL])
		else $error("reply on unselected interface");
	a_addr_range: assert property (bus_address >= RCI_ADDR_MIN && bus_address <= RCI_ADDR_MAX)
		else $error("bus address out of range");
	a_srq_hold: assert property (led_srq && !bus_spoll_done |=> led_srq)
		else $error("service request dropped before poll");
	a_srq_set: assert property (srq_req |=> led_srq)
		else $error("service request not shown");
	a_sync_follow: assert property (##1 sync_out == $past(osc_sine_pos))
		else $error("sync output not following oscillator");
	a_software_trigger_command_start: assert property (ext_software_trigger_command && !s_q.software_trigger_command_prev && s_q.gap == '0 && s_q.ctrl[RCI_CTRL_TSTART] && !storing
		|=> sample_strobe && storing)
		else $error("trigger start missed first sample");
	a_software_trigger_command_gap: assert property (sample_strobe |=> !sample_strobe[*8])
		else $error("samples closer than minimum period");
	a_overflow: assert property (ser_rx_valid && ser_rx_data != RCI_CH_SP && s_q.in_cnt == FULL
		|=> s_q.in_cnt == '0 && s_q.out_cnt == '0 && led_error)
		else $error("overflow did not clear queues");
	a_full_hold: assert property (s_q.in_cnt == FULL |-> !ser_cts && !bus_rx_ready)
		else $error("handshake not held off when full");
	a_err_pulse: assert property (exec_err |=> led_error)
		else $error("error indicator missed fault");
	a_act_pulse: assert property (ser_rx_valid |=> led_activity)
		else $error("activity indicator missed character");

	c_line_done: cover property (s_q.ex == RCI_EX_WAIT ##1 s_q.ex == RCI_EX_IDLE);
	c_reply_bus: cover property (bus_tx_valid && bus_tx_ready);
	c_overflow: cover property (s_q.in_cnt == FULL && ser_rx_valid);
	c_software_trigger_command_sample: cover property (storing && sample_strobe);

endmodule // rci_top

// ---- hdl/rci_pkg.sv ----
// Constants, offsets and types of the remote command interface
//
// Summary of operation
// - Trigger-start mode: a rising trigger edge starts storage and records first sample.
// - Triggered rate: one sample per rising edge; triggers no faster than 512 Hz.
// - Sync output is a square wave following oscillator sine zero crossings, always.
// - Receive on both interfaces always; send replies only on the selected one.
// - Bus address is settable only from 1 to 30.
// - Serial word length is always 8 bits; baud and parity are settable.
// - Drive CTS when ready; gate serial sending on host DTR; handshake optional (CTS and DTR gating here are always on, with no switch).
// - Activity indicator pulses on every character received or sent.
// - Error indicator pulses on a detected fault.
// - Service-request indicator holds from request until a serial poll completes.
// - Keep the last 256 received characters for the hex queue display.
// - Command letters are case-insensitive; embedded spaces are ignored.
// - Command is mnemonic, arguments, terminator; nothing runs before a terminator.
// - Commas split parameters, semicolons commands; whole line runs before anything else.
// - 256-char input queue in arrival order; when full, hold off handshaking.
// - 256-char output queue; overflow of either clears both and reports error.
// - Query is mnemonic plus question mark; replies end CR serial, LF bus.
// - Several queries on one line each get their own terminated answer.
// - Ready bit 1 clears on command, sets on completion; others wait buffered.
// - During execution only serial poll answers; status queries wait for completion.
// - Bus trigger message acts as trigger input, only in triggered or start mode.
// - Asterisk common commands behave the same on bus and serial.

package rci_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] RCI_REG_CTRL = 8'h00;
	localparam logic [7:0] RCI_REG_ADDR = 8'h04;
	localparam logic [7:0] RCI_REG_STAT = 8'h08;
	localparam logic [7:0] RCI_REG_HIDX = 8'h0C;
	localparam logic [7:0] RCI_REG_HDAT = 8'h10;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         RCI_CTRL_OSEL   = 0;
	localparam int         RCI_CTRL_TSTART = 1;
	localparam int         RCI_CTRL_TRATE  = 2;
	localparam int         RCI_CTRL_PAR    = 3;
	localparam int         RCI_CTRL_BAUD   = 5;
	localparam logic [7:0] RCI_CTRL_RST    = 8'h00;
	localparam int         RCI_STAT_READY  = 1;
	localparam int         RCI_STAT_SRQ    = 2;
	localparam int         RCI_STAT_ERR    = 3;
	localparam int         RCI_STAT_STORE  = 4;
	localparam logic [4:0] RCI_ADDR_MIN    = 5'h01;
	localparam logic [4:0] RCI_ADDR_MAX    = 5'h1E;
	localparam logic [4:0] RCI_ADDR_RST    = 5'h08;
	localparam logic [3:0] RCI_WORD_LEN    = 4'h8;

	// ****************************************
	// Characters
	// ****************************************
	localparam logic [7:0] RCI_CH_LF = 8'h0A;
	localparam logic [7:0] RCI_CH_CR = 8'h0D;
	localparam logic [7:0] RCI_CH_SP = 8'h20;
	localparam logic [7:0] RCI_CH_A  = 8'h61;
	localparam logic [7:0] RCI_CH_Z  = 8'h7A;
	localparam logic [7:0] RCI_CASE  = 8'h20;

	// ****************************************
	// Timing
	// ****************************************
	localparam int RCI_CLK_NS       = 4;
	localparam int RCI_SOFTWARE_TRIGGER_COMMAND_MIN_NS  = 1953125;
	localparam int RCI_SOFTWARE_TRIGGER_COMMAND_GAP_CYC = (RCI_SOFTWARE_TRIGGER_COMMAND_MIN_NS + RCI_CLK_NS - 1) / RCI_CLK_NS;

	typedef enum logic [1:0] {
		RCI_EX_IDLE = 2'b00,
		RCI_EX_SEND = 2'b01,
		RCI_EX_WAIT = 2'b10
	} rci_ex_t;

endpackage

// ---- verif/rci_host_model.sv ----
// Host computer model: sends characters on serial and instrument bus, takes replies
`timescale 1ns/1ps

module rci_host_model (
	// Clock
	input  wire logic       mclk,
	// Serial side
	output logic            ser_rx_valid,
	output logic      [7:0] ser_rx_data,
	input  wire logic       ser_tx_valid,
	input  wire logic [7:0] ser_tx_data,
	output logic            ser_tx_ready,
	output logic            ser_dtr,
	// Instrument bus side
	output logic            bus_rx_valid,
	output logic      [7:0] bus_rx_data,
	output logic            bus_rx_eoi,
	input  wire logic       bus_rx_ready,
	input  wire logic       bus_tx_valid,
	input  wire logic [7:0] bus_tx_data,
	output logic            bus_tx_ready
);
	logic [7:0] ser_q [$];
	logic [7:0] bus_q [$];

	initial begin
		ser_rx_valid = 1'b0;
		ser_rx_data  = 8'h00;
		ser_tx_ready = 1'b1;
		ser_dtr      = 1'b1;
		bus_rx_valid = 1'b0;
		bus_rx_data  = 8'h00;
		bus_rx_eoi   = 1'b0;
		bus_tx_ready = 1'b0;
	end

	// Slow bus listener: accepts every other cycle
	always @(posedge mclk) begin
		bus_tx_ready <= ~bus_tx_ready;
	end

	// Replies are taken at the falling edge
	always @(negedge mclk) begin
		if (ser_tx_valid === 1'b1 && ser_tx_ready === 1'b1) begin
			ser_q.push_back(ser_tx_data);
		end
		if (bus_tx_valid === 1'b1 && bus_tx_ready === 1'b1) begin
			bus_q.push_back(bus_tx_data);
		end
	end

	task automatic ser_send(input logic [7:0] c);
		@(posedge mclk);
		ser_rx_valid <= 1'b1;
		ser_rx_data  <= c;
		@(posedge mclk);
		ser_rx_valid <= 1'b0;
		ser_rx_data  <= ~c;
	endtask

	// Holds the byte until the device accepts it
	task automatic bus_send(input logic [7:0] c, input logic last);
		@(posedge mclk);
		bus_rx_valid <= 1'b1;
		bus_rx_data  <= c;
		bus_rx_eoi   <= last;
		for (int i = 0; i < 400; i++) begin
			@(negedge mclk);
			if (bus_rx_ready === 1'b1) break;
		end
		@(posedge mclk);
		bus_rx_valid <= 1'b0;
		bus_rx_data  <= ~c;
		bus_rx_eoi   <= 1'b0;
	endtask

	// Host side DTR level, changed just after a rising edge
	task automatic set_dtr(input logic v);
		@(posedge mclk);
		ser_dtr <= v;
	endtask
endmodule // rci_host_model

// ---- verif/tb.sv ----
// Self-checking testbench of the remote command interface
`timescale 1ns/1ps

module tb;
	import rci_pkg::*;
	localparam int GAP = 20;

	logic        mclk, rst_b, reg_wr, reg_rd, osc_sine_pos;
	logic [7:0]  reg_addr, resp_char;
	logic [31:0] reg_wdata, reg_rdata;
	logic [8:0]  ev;
	logic        ser_rx_valid, ser_tx_valid, ser_tx_ready, ser_cts, ser_dtr;
	logic [7:0]  ser_rx_data, ser_tx_data, bus_rx_data, bus_tx_data, cmd_char;
	logic [3:0]  ser_word_len;
	logic [1:0]  ser_parity;
	logic [2:0]  ser_baud;
	logic [4:0]  bus_address;
	logic        bus_rx_valid, bus_rx_eoi, bus_rx_ready, bus_tx_valid, bus_tx_ready;
	logic        cmd_valid, cmd_last, sample_strobe, storing, sync_out, led_activity, led_error, led_srq;
	logic [8:0]  cmd_q [$];
	int          errors, n_tests, n_act, n_err, n_smp;

	// ****************************************
	// Design, host model, clock
	// ****************************************
	rci_top #(.SOFTWARE_TRIGGER_COMMAND_GAP(GAP)) dut (
		.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
		.ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready), .ser_cts(ser_cts),
		.ser_dtr(ser_dtr), .ser_word_len(ser_word_len), .ser_parity(ser_parity), .ser_baud(ser_baud),
		.bus_rx_valid(bus_rx_valid), .bus_rx_data(bus_rx_data), .bus_rx_eoi(bus_rx_eoi),
		.bus_rx_ready(bus_rx_ready), .bus_tx_valid(bus_tx_valid), .bus_tx_data(bus_tx_data),
		.bus_tx_ready(bus_tx_ready), .bus_address(bus_address), .bus_get(ev[4]), .bus_spoll_done(ev[5]),
		.cmd_valid(cmd_valid), .cmd_char(cmd_char), .cmd_last(cmd_last), .exec_done(ev[0]), .exec_err(ev[1]),
		.resp_valid(ev[7]), .resp_char(resp_char), .resp_eol(ev[8]), .srq_req(ev[2]), .sw_software_trigger_command(ev[3]),
		.ext_software_trigger_command(ev[6]), .sample_strobe(sample_strobe), .storing(storing), .osc_sine_pos(osc_sine_pos),
		.sync_out(sync_out), .led_activity(led_activity), .led_error(led_error), .led_srq(led_srq));

	rci_host_model host (
		.mclk(mclk), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data), .ser_tx_valid(ser_tx_valid),
		.ser_tx_data(ser_tx_data), .ser_tx_ready(ser_tx_ready), .ser_dtr(ser_dtr), .bus_rx_valid(bus_rx_valid),
		.bus_rx_data(bus_rx_data), .bus_rx_eoi(bus_rx_eoi), .bus_rx_ready(bus_rx_ready),
		.bus_tx_valid(bus_tx_valid), .bus_tx_data(bus_tx_data), .bus_tx_ready(bus_tx_ready));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(negedge mclk) begin
		if (cmd_valid === 1'b1) cmd_q.push_back({cmd_last, cmd_char});
		n_act += (led_activity === 1'b1);
		n_err += (led_error === 1'b1);
		n_smp += (sample_strobe === 1'b1);
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	task automatic pulse(input int b, input logic [7:0] c = 8'h00);
		@(posedge mclk);
		ev[b]     <= 1'b1;
		resp_char <= c;
		@(posedge mclk);
		ev[b] <= 1'b0;
	endtask

	task automatic wait_last;
		for (int i = 0; i < 60; i++) begin
			if (cmd_q.size() > 0 && cmd_q[$][8] === 1'b1) break;
			cyc(1);
		end
	endtask

	task automatic chk_cmds(input logic [8:0] e [4]);
		chk("cmd count", 32'h4, cmd_q.size());
		for (int i = 0; i < 4; i++) begin
			chk("cmd char", {23'h0, e[i]}, (i < cmd_q.size()) ? {23'h0, cmd_q[i]} : 32'hFFFFFFFF);
		end
		cmd_q.delete();
	endtask

	task automatic finish_test;
		$display("Checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(4 * 20000);
		errors++;
		finish_test();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		logic [31:0] d;
		int          b0;
		rst_b        = 1'b0;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		reg_addr     = 8'h00;
		reg_wdata    = 32'h0;
		resp_char    = 8'h00;
		ev           = 9'h000;
		osc_sine_pos = 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		rd(RCI_REG_ADDR, d);
		chk("addr reset", 32'h8, d);
		rd(RCI_REG_STAT, d);
		chk("stat reset", 32'h2, d);
		rd(8'h40, d);
		chk("unmapped", 32'h0, d);
		chk("word len", 32'h8, ser_word_len);
		wr(RCI_REG_CTRL, 32'hE8);
		chk("baud", 32'h7, ser_baud);
		chk("parity", 32'h1, ser_parity);
		wr(RCI_REG_CTRL, 32'h0);
		// Address range and error pulses
		b0 = n_err;
		wr(RCI_REG_ADDR, 32'h1E);
		chk("addr 30", 32'h1E, bus_address);
		wr(RCI_REG_ADDR, 32'h1F);
		wr(RCI_REG_ADDR, 32'h0);
		chk("addr kept", 32'h1E, bus_address);
		pulse(1);
		cyc(2);
		chk("error pulses", 32'h3, n_err - b0);
		rd(RCI_REG_STAT, d);
		chk("err bit", 32'h8, d & 32'h8);
		wr(RCI_REG_STAT, 32'h8);
		// Serial line, case folding, space removal
		b0 = n_act;
		host.ser_send(8'h61);
		host.ser_send(RCI_CH_SP);
		host.ser_send(8'h62);
		host.ser_send(8'h3F);
		cmd_q.delete();
		cyc(5);
		chk("no early cmd", 32'h0, cmd_q.size());
		host.ser_send(RCI_CH_LF);
		wait_last();
		rd(RCI_REG_STAT, d);
		chk("ready low", 32'h0, d & 32'h2);
		chk("rx activity", 32'h5, n_act - b0);
		chk_cmds('{9'h041, 9'h042, 9'h03F, 9'h10A});
		// History holds raw chars, oldest of the last 256 at index 0
		wr(RCI_REG_HIDX, 32'hFC);
		rd(RCI_REG_HDAT, d);
		chk("hist space", 32'h20, d);
		wr(RCI_REG_HIDX, 32'hFF);
		rd(RCI_REG_HDAT, d);
		chk("hist newest", 32'h0A, d);
		// Bus line waits for the running one
		host.bus_send(8'h2A, 1'b0);
		host.bus_send(8'h63, 1'b0);
		host.bus_send(8'h6C, 1'b0);
		host.bus_send(8'h73, 1'b1);
		cyc(10);
		chk("held line", 32'h0, cmd_q.size());
		pulse(0);
		wait_last();
		chk_cmds('{9'h02A, 9'h043, 9'h04C, 9'h153});
		pulse(0);
		cyc(3);
		rd(RCI_REG_STAT, d);
		chk("ready back", 32'h2, d);
		// Replies: DTR stall, serial then bus
		host.set_dtr(1'b0);
		b0 = n_act;
		pulse(7, 8'h58);
		pulse(8);
		cyc(10);
		chk("dtr stall", 32'h0, host.ser_q.size());
		host.set_dtr(1'b1);
		cyc(20);
		chk("ser count", 32'h2, host.ser_q.size());
		chk("ser char", 32'h58, host.ser_q[0]);
		chk("ser term", 32'h0D, host.ser_q[1]);
		chk("tx activity", 32'h2, n_act - b0);
		wr(RCI_REG_CTRL, 32'h1);
		pulse(7, 8'h59);
		pulse(8);
		cyc(30);
		chk("bus count", 32'h2, host.bus_q.size());
		chk("bus char", 32'h59, host.bus_q[0]);
		chk("bus term", 32'h0A, host.bus_q[1]);
		chk("ser quiet", 32'h2, host.ser_q.size());
		// Triggers
		wr(RCI_REG_CTRL, 32'h6);
		b0 = n_smp;
		pulse(6);
		cyc(3);
		chk("storing", 32'h1, storing);
		chk("first sample", 32'h1, n_smp - b0);
		pulse(6);
		cyc(3);
		chk("early trigger", 32'h1, n_smp - b0);
		cyc(GAP + 5);
		pulse(4);
		cyc(GAP + 5);
		pulse(3);
		cyc(3);
		chk("bus and sw software_trigger_command", 32'h3, n_smp - b0);
		wr(RCI_REG_CTRL, 32'h0);
		chk("stop storing", 32'h0, storing);
		cyc(GAP + 5);
		pulse(4);
		cyc(3);
		chk("software_trigger_command off", 32'h3, n_smp - b0);
		// Sync follows the sine sign
		for (int k = 1; k < 6; k++) begin
			@(posedge mclk);
			osc_sine_pos <= k[0];
			cyc(1);
			chk("sync", {31'h0, k[0]}, sync_out);
		end
		// Service request held until poll
		pulse(2);
		cyc(12);
		chk("srq on", 32'h1, led_srq);
		pulse(5);
		cyc(3);
		chk("srq off", 32'h0, led_srq);
		// Input queue full, then overflow
		b0 = n_err;
		for (int k = 0; k < 256; k++) host.ser_send(8'h61);
		cyc(2);
		chk("cts full", 32'h0, ser_cts);
		chk("bus hold", 32'h0, bus_rx_ready);
		host.ser_send(8'h61);
		cyc(3);
		chk("overflow err", 32'h1, n_err - b0);
		chk("cts flushed", 32'h1, ser_cts);
		finish_test();
	end
endmodule // tb
